// ===== rtl/ucms_sequencer.sv
// What this block does
// - entering automatic dedicated charging starts in the divider bias scheme
// - divider bias scheme biases both data lines at 2.7 V
// - compliant attach: power stays on without discharge, brief 1.2 V, then shorted
// - shorted mode holds until data line released, then back to divider bias
// - divider-compliant device attached keeps machine in divider bias
// - shorted mode ties D+ to D- through at most 200 ohms
// - 1.2 V scheme shorts and pulls lines to 1.2 V for fixed time
// - client mode keeps power switch off and data pass switch on
// - pass switches close in CDP, SDP or client mode
// - pass switches enable only while enable input is high
// - pass switches open when enable low or dedicated charging selected
// - current limit alone never opens the pass switches
// - CDP keeps pass switches closed through the detection handshake
// - pass switches stay open while output bus discharges
// - mode inputs: 00x DCP, 01x SDP, 10x client, 110 SDP, 111 CDP
`timescale 1ns/1ps
`default_nettype none
module ucms_sequencer
  import ucms_pkg::*;
#(
  parameter int ONE_V_TWO_LEN = ONE_V_TWO_CYCLES
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control pins, asynchronous
  input  wire logic enable,
  input  wire logic modeSelectA,
  input  wire logic modeSelectB,
  input  wire logic modeSelectC,
  // analog status, asynchronous
  input  wire logic compliantAttach,
  input  wire logic dataLineReleased,
  input  wire logic outDischarging,
  input  wire logic currentLimit,
  // analog controls
  output logic      powerSwitchOn,
  output logic      passSwitchOn,
  output logic      dividerBiasOn,
  output logic      oneVTwoPullOn,
  output logic      dataShortOn,
  output logic      cdpDetectOn,
  output ucms_mode_t modeOut,
  output ucms_det_t  detState
);

  localparam int SYNC_W = 7;

  logic [SYNC_W-1:0] syncFirst_reg;
  logic [SYNC_W-1:0] syncSecond_reg;
  logic              enS, attachS, releaseS, dischS;
  logic [2:0]        selS;
  ucms_mode_t        mode_reg;
  ucms_mode_t        mode_next;
  ucms_det_t         det_reg;
  ucms_det_t         det_next;
  logic [31:0]       timer_reg;
  logic              timerDone;

  // decode of the three select inputs
  function automatic ucms_mode_t decodeMode(input logic [2:0] sel);
    ucms_mode_t m;
    m = MODE_DCP;
    case (sel[SEL_A_POS -: 2])
      2'h0: m = MODE_DCP;
      2'h1: m = MODE_SDP;
      2'h2: m = MODE_CLIENT;
      default: m = sel[SEL_C_POS] ? MODE_CDP : MODE_SDP;
    endcase
    return m;
  endfunction

  // two-stage synchronisers for pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // select bits rest at the reset mode's code, so release starts no false dcp pass
      syncFirst_reg  <= {1'b0, SEL_RESET_CODE, 3'h0};
      syncSecond_reg <= {1'b0, SEL_RESET_CODE, 3'h0};
    end else begin
      syncFirst_reg  <= {enable, modeSelectA, modeSelectB, modeSelectC,
                         compliantAttach, dataLineReleased, outDischarging};
      syncSecond_reg <= syncFirst_reg;
    end
  end

  assign enS      = syncSecond_reg[6];
  assign selS     = syncSecond_reg[5:3];
  assign attachS  = syncSecond_reg[2];
  assign releaseS = syncSecond_reg[1];
  assign dischS   = syncSecond_reg[0];
  assign mode_next = decodeMode(selS);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_SDP;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign timerDone = (timer_reg == 32'(ONE_V_TWO_LEN - 1));

  always_comb begin
    det_next = det_reg;
    case (det_reg)
      DET_IDLE: begin
        if (mode_reg == MODE_DCP) begin
          det_next = DET_DIVIDER;
        end
      end
      DET_DIVIDER: begin
        // stay unless a compliant device attaches
        if (attachS) begin
          det_next = DET_ONE_V_TWO;
        end
      end
      DET_ONE_V_TWO: begin
        if (timerDone) begin
          det_next = DET_SHORTED;
        end
      end
      DET_SHORTED: begin
        if (releaseS) begin
          det_next = DET_DIVIDER;
        end
      end
      default: det_next = DET_IDLE;
    endcase
    if (mode_reg != MODE_DCP) begin
      det_next = DET_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      det_reg <= DET_IDLE;
    end else begin
      det_reg <= det_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else if (det_reg == DET_ONE_V_TWO && !timerDone) begin
      timer_reg <= timer_reg + 32'h1;
    end else if (det_reg != DET_ONE_V_TWO) begin
      timer_reg <= '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      powerSwitchOn <= 1'b0;
      passSwitchOn  <= 1'b0;
      dividerBiasOn <= 1'b0;
      oneVTwoPullOn <= 1'b0;
      dataShortOn   <= 1'b0;
      cdpDetectOn   <= 1'b0;
    end else begin
      // client mode blocks output power; no discharge on attach
      powerSwitchOn <= enS && (mode_reg != MODE_CLIENT);
      passSwitchOn  <= enS && !dischS && (mode_reg != MODE_DCP);
      dividerBiasOn <= enS && (det_reg == DET_DIVIDER);
      // 1.2 V pull with lines shorted
      oneVTwoPullOn <= enS && (det_reg == DET_ONE_V_TWO);
      dataShortOn   <= enS && (det_reg == DET_ONE_V_TWO || det_reg == DET_SHORTED);
      // CDP detection response on data lines
      cdpDetectOn   <= enS && (mode_reg == MODE_CDP);
    end
  end

  assign modeOut  = mode_reg;
  assign detState = det_reg;

  // pass switches open in dedicated charging
  a_pass_off_dcp: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(mode_reg) == MODE_DCP |-> !passSwitchOn) else $error("pass on in dcp");
  a_pass_needs_en: assert property (@(posedge mclk) disable iff (!rst_n)
    passSwitchOn |-> $past(enS)) else $error("pass on without enable");
  a_pass_off_disch: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(dischS) |-> !passSwitchOn) else $error("pass on during discharge");
  a_pass_on_data: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(enS) && !$past(dischS) && $past(mode_reg) != MODE_DCP) |-> passSwitchOn)
    else $error("pass off in data mode");
  a_pass_curlim: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(currentLimit) && $past(enS) && !$past(dischS) && $past(mode_reg) != MODE_DCP)
    |-> passSwitchOn) else $error("pass off under current limit");
  a_client_power_off: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(mode_reg) == MODE_CLIENT |-> !powerSwitchOn) else $error("power on in client");
  a_dcp_start_div: assert property (@(posedge mclk) disable iff (!rst_n)
    (det_reg == DET_IDLE && mode_reg == MODE_DCP) |=> det_reg == DET_DIVIDER)
    else $error("dcp not starting in divider");
  a_div_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (det_reg == DET_DIVIDER && !attachS && mode_reg == MODE_DCP) |=> det_reg == DET_DIVIDER)
    else $error("divider left without attach");
  a_short_release: assert property (@(posedge mclk) disable iff (!rst_n)
    (det_reg == DET_SHORTED && releaseS && mode_reg == MODE_DCP) |=> det_reg == DET_DIVIDER)
    else $error("shorted not returning");
  a_onev_to_short: assert property (@(posedge mclk) disable iff (!rst_n)
    (det_reg == DET_ONE_V_TWO && timerDone && mode_reg == MODE_DCP) |=> det_reg == DET_SHORTED)
    else $error("1.2 V scheme not ending");
  a_attach_onev: assert property (@(posedge mclk) disable iff (!rst_n)
    (det_reg == DET_DIVIDER && attachS && mode_reg == MODE_DCP) |=> det_reg == DET_ONE_V_TWO)
    else $error("attach not moving to 1.2 V");
  a_leave_dcp_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_reg != MODE_DCP |=> det_reg == DET_IDLE) else $error("detection kept outside dcp");
  a_divider_bias: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(det_reg) == DET_DIVIDER && $past(enS)) |-> dividerBiasOn)
    else $error("divider bias missing");
  a_shorted_lines: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(det_reg) == DET_SHORTED && $past(enS)) |-> (dataShortOn && !oneVTwoPullOn))
    else $error("lines not shorted in shorted mode");

endmodule
`default_nettype wire

// ===== rtl/ucms_pkg.sv
package ucms_pkg;

  // charging personality selected by the mode inputs
  typedef enum logic [1:0] {
    MODE_DCP,
    MODE_SDP,
    MODE_CLIENT,
    MODE_CDP
  } ucms_mode_t;

  // automatic dedicated-charging detection states
  typedef enum logic [1:0] {
    DET_IDLE,
    DET_DIVIDER,
    DET_ONE_V_TWO,
    DET_SHORTED
  } ucms_det_t;

  // duration of the 1.2 V scheme, in microseconds
  localparam int ONE_V_TWO_TIME_US = 100;
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int ONE_V_TWO_CYCLES  = (ONE_V_TWO_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES       = 2;

  // select code the synchroniser holds in reset, matching the reset mode (SDP)
  localparam logic [2:0] SEL_RESET_CODE = 3'h2;

  // mode-select field positions within the combined 3-bit code
  localparam int SEL_A_POS = 2;
  localparam int SEL_B_POS = 1;
  localparam int SEL_C_POS = 0;

endpackage

// ===== sim/ucms_portable_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucms_portable_model (
  // clock
  input  wire logic mclk,
  // bench commands
  input  wire logic plugCmd,
  input  wire logic releaseCmd,
  // levels sensed by the port
  output var  logic compliantAttach,
  output var  logic dataLineReleased
);
  // plug reads as a compliant attach, release reads as data line released and drops the attach
  always @(posedge mclk) begin
    compliantAttach  <= plugCmd && !releaseCmd;
    dataLineReleased <= releaseCmd;
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ucms_pkg::*;
  localparam int LEN = 8;
  logic       mclk = 1'b0, rst_n = 1'b0, enable = 1'b1;
  logic       selA = 1'b0, selB = 1'b1, selC = 1'b0;
  logic       outDis = 1'b0, curLim = 1'b0, plug = 1'b0, rel = 1'b0;
  logic       attach, released, powerOn, passOn, divOn, pullOn, shortOn, cdpOn;
  ucms_mode_t mode;
  ucms_det_t  det;
  int         fail_count = 0, total_checks = 0, cycles = 0;
  always #2.5 mclk = ~mclk;
  ucms_sequencer #(.ONE_V_TWO_LEN(LEN)) dut (.mclk(mclk), .rst_n(rst_n), .enable(enable),
    .modeSelectA(selA), .modeSelectB(selB), .modeSelectC(selC), .compliantAttach(attach),
    .dataLineReleased(released), .outDischarging(outDis), .currentLimit(curLim),
    .powerSwitchOn(powerOn), .passSwitchOn(passOn), .dividerBiasOn(divOn),
    .oneVTwoPullOn(pullOn), .dataShortOn(shortOn), .cdpDetectOn(cdpOn),
    .modeOut(mode), .detState(det));
  ucms_portable_model peer (.mclk(mclk), .plugCmd(plug), .releaseCmd(rel),
    .compliantAttach(attach), .dataLineReleased(released));
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic mode_table;
    ucms_mode_t m;
    for (int i = 0; i < 8; i++) begin
      {selA, selB, selC} = i[2:0];
      step(6);
      m = i[2:1] == 2'h0 ? MODE_DCP : i[2:1] == 2'h1 ? MODE_SDP :
          i[2:1] == 2'h2 ? MODE_CLIENT : i[0] ? MODE_CDP : MODE_SDP;
      check(mode, m);
      check({1'b0, passOn}, {1'b0, m != MODE_DCP});
      check({1'b0, powerOn}, {1'b0, m != MODE_CLIENT});
      check({1'b0, cdpOn}, {1'b0, m == MODE_CDP});
    end
  endtask
  task automatic gate_cases;
    {selA, selB, selC} = 3'h7;
    curLim = 1'b1;
    step(6);
    check({1'b0, passOn}, 2'h1);
    outDis = 1'b1;
    step(6);
    check({1'b0, passOn}, 2'h0);
    outDis = 1'b0;
    enable = 1'b0;
    step(6);
    check({1'b0, passOn}, 2'h0);
    check({1'b0, cdpOn}, 2'h0);
    enable = 1'b1;
    curLim = 1'b0;
    step(6);
    check({1'b0, passOn}, 2'h1);
  endtask
  task automatic dcp_sequence;
    {selA, selB, selC} = 3'h0;
    step(6);
    check(det, DET_DIVIDER);
    check({divOn, shortOn}, 2'h2);
    step(20);
    check(det, DET_DIVIDER);
    plug = 1'b1;
    step(5);
    check(det, DET_ONE_V_TWO);
    check({pullOn, shortOn}, 2'h3);
    check({powerOn, passOn}, 2'h2);
    step(LEN + 4);
    check(det, DET_SHORTED);
    check({pullOn, shortOn}, 2'h1);
    step(20);
    check(det, DET_SHORTED);
    rel = 1'b1;
    plug = 1'b0;
    step(6);
    check(det, DET_DIVIDER);
    rel = 1'b0;
    {selA, selB, selC} = 3'h2;
    step(6);
    check(det, DET_IDLE);
    {selA, selB, selC} = 3'h1;
    step(6);
    check(det, DET_DIVIDER);
  endtask
  initial begin
    step(20);
    rst_n = 1'b1;
    step(4);
    mode_table();
    gate_cases();
    dcp_sequence();
    end_sim();
  end
endmodule
`default_nettype wire
